/* hdl/dce_consts.svh */
/*
 * Offsets, field positions, reset values and timing counts of the
 * dual comparator event logic.
 * Assumes a 10 MHz system clock and byte addresses on an APB bus with 8-bit addresses and 32-bit data.
 */
`ifndef DCE_CONSTS_SVH
`define DCE_CONSTS_SVH

// Register byte offsets
`define DCE_OFF_CFG0    8'h00
`define DCE_CFG_STEP    8'h04
`define DCE_OFF_PWR     8'h08
`define DCE_OFF_STAT    8'h0c
`define DCE_OFF_MASK    8'h10

// Comparator configuration register fields
`define DCE_B_EN        0
`define DCE_B_POSB      1
`define DCE_B_NEGREF    2
`define DCE_B_PINEN     3
`define DCE_B_INTEN     4
`define DCE_B_RESULT    5
`define DCE_B_FLAG      6
`define DCE_B_SETTLED   7

// Power control register fields
`define DCE_B_MODE_LO   0
`define DCE_B_MODE_HI   1
`define DCE_B_CMPOFF    5

// Reset values
`define DCE_RST_WORD    32'h0000_0000
`define DCE_RST_CMPOFF  1'b0

// Settling time after enable, in microseconds, and its cycle count
`define DCE_SETTLE_US   10
`define DCE_CLK_KHZ     10000
`define DCE_SETTLE_CYC  ((`DCE_SETTLE_US * `DCE_CLK_KHZ) / 1000)

`endif

/* hdl/dce_pkg.sv */
/*
 * Types of the dual comparator event logic.
 * Includes nothing from dce_consts.svh; the power mode encodings are set here.
 */
package dce_pkg;

    // Processor power mode, supplied by the system controller
    typedef enum logic [1:0] {
        MODE_RUN  = 2'b00,
        MODE_IDLE = 2'b01,
        MODE_PD   = 2'b10,
        MODE_TPD  = 2'b11
    } dce_mode_t;

    // Software configuration of one comparator
    typedef struct packed {
        logic pin_en;
        logic neg_ref;
        logic pos_b;
        logic en;
    } dce_cfg_t;

    // Control handed to the analog front end of one comparator
    typedef struct packed {
        logic en;
        logic pos_b;
        logic neg_ref;
    } dce_fe_t;

endpackage

/* hdl/dce_cmp_chan.sv */
/*
 * One comparator channel: synchroniser, forced-high result while
 * disabled, change detection, sticky change flag and settle timer.
 * Assumes raw_gt comes straight from an analog comparator, unsynchronised.
 */
`timescale 1ns/10ps
`include "dce_consts.svh"
module dce_cmp_chan #(
    parameter int SETTLE = `DCE_SETTLE_CYC
) (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic en,
    input  wire logic raw_gt,
    input  wire logic clr,
    output logic      result,
    output logic      flag,
    output logic      change,
    output logic      settled
);
    logic [7:0] cnt,  next_cnt;
    logic       sync1, sync2;
    logic       next_result, next_flag;

    // Two-stage synchroniser on the analog result
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1 <= 1'b1;
            sync2 <= 1'b1;
        end else begin
            sync1 <= raw_gt;
            sync2 <= sync1;
        end
    end

    // Result, change pulse, sticky flag and settle count
    always_comb begin
        next_result = en ? sync2 : 1'b1;
        change      = (next_result != result);
        next_flag   = change | (flag & ~clr);
        next_cnt    = cnt;
        if (!en) begin
            next_cnt = 8'h00;
        end else if (cnt != 8'(SETTLE)) begin
            next_cnt = cnt + 8'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            result <= 1'b1;
            flag   <= 1'b0;
            cnt    <= 8'h00;
        end else begin
            result <= next_result;
            flag   <= next_flag;
            cnt    <= next_cnt;
        end
    end

    assign settled = (cnt == 8'(SETTLE));

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_disabled_high: assert property (!en |=> result)
        else $error("Disabled comparator result not high");
    a_sync_path: assert property (
        $past(en) && $past(rst_b, 3) |-> result == $past(raw_gt, 3))
        else $error("Result does not follow input after two stages");
    a_flag_on_change: assert property (
        result != $past(result) |-> flag)
        else $error("Change flag missed a result change");
    a_flag_hold: assert property (flag && !clr |=> flag)
        else $error("Change flag dropped without a clear");
    a_zero_disable: assert property (!result && !en |=> flag)
        else $error("Disable from low did not set the flag");
endmodule

/* hdl/dce_top.sv */
/*
 * Dual comparator event logic: APB register file, two comparator
 * channels, pin routing, shared interrupt and wake request.
 * Assumes an APB master on clk, a front end that returns one compare
 * bit per comparator, and a system controller that reports power mode.
 */
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`include "dce_consts.svh"
module dce_top #(
    parameter int NCMP   = 2,
    parameter int SETTLE = `DCE_SETTLE_CYC
) (
    input  wire logic                      clk,
    input  wire logic                      rst_b,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [7:0]                paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  dce_pkg::dce_mode_t             pwr_mode,
    input  wire logic [NCMP-1:0]           raw_gt,
    output dce_pkg::dce_fe_t [NCMP-1:0]    fe_ctl,
    output logic      [NCMP-1:0]           cmp_pin_out,
    output logic      [NCMP-1:0]           cmp_pin_oe_b,
    output logic                           irq,
    output logic                           wake
);
    // Register map: one configuration word per comparator, then power
    // control, a status word of change flags and an interrupt mask word.
    // The interrupt enable bit of a configuration word and its mask bit
    // are the same flop, so software may use either view.
    dce_pkg::dce_cfg_t [NCMP-1:0] cfg,       next_cfg;
    logic              [NCMP-1:0] int_mask,  next_int_mask;
    logic                         cmp_off,   next_cmp_off;
    logic              [31:0]     next_prdata;
    logic              [NCMP-1:0] next_pin,  next_oe_b;
    logic                         next_irq,  next_wake;
    logic              [NCMP-1:0] en_eff;
    logic              [NCMP-1:0] clr;
    logic              [NCMP-1:0] result;
    logic              [NCMP-1:0] flag;
    logic              [NCMP-1:0] change;
    logic              [NCMP-1:0] settled;
    logic                         setup, acc, wr, mapped, tpd, asleep;

    // Address match, used by read, write and error decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    // Byte address of one comparator configuration register
    function automatic logic [7:0] cfg_addr(input int i);
        cfg_addr = `DCE_OFF_CFG0 + 8'(i) * `DCE_CFG_STEP;
    endfunction

    // Bus phase decode and mode decode
    assign setup  = psel & ~penable;
    assign acc    = psel & penable;
    assign wr     = acc & pwrite;
    assign tpd    = (pwr_mode == dce_pkg::MODE_TPD);
    assign asleep = (pwr_mode == dce_pkg::MODE_IDLE) | (pwr_mode == dce_pkg::MODE_PD);

    // Mapped-address check
    always_comb begin
        mapped = hit(paddr, `DCE_OFF_PWR) | hit(paddr, `DCE_OFF_STAT)
               | hit(paddr, `DCE_OFF_MASK);
        for (int i = 0; i < NCMP; i++) begin
            if (hit(paddr, cfg_addr(i))) begin
                mapped = 1'b1;
            end
        end
    end

    // Zero-wait slave; unmapped access answers with an error
    assign pready  = 1'b1;
    assign pslverr = acc & ~mapped;

    // Register writes, flag clears and automatic disable
    always_comb begin
        next_cfg      = cfg;
        next_int_mask = int_mask;
        next_cmp_off  = cmp_off;
        clr           = '0;
        if (wr) begin
            for (int i = 0; i < NCMP; i++) begin
                if (hit(paddr, cfg_addr(i))) begin
                    next_cfg[i].en      = pwdata[`DCE_B_EN];
                    next_cfg[i].pos_b   = pwdata[`DCE_B_POSB];
                    next_cfg[i].neg_ref = pwdata[`DCE_B_NEGREF];
                    next_cfg[i].pin_en  = pwdata[`DCE_B_PINEN];
                    next_int_mask[i]    = pwdata[`DCE_B_INTEN];
                    clr[i]              = ~pwdata[`DCE_B_FLAG];
                end
            end
            if (hit(paddr, `DCE_OFF_PWR)) begin
                next_cmp_off = pwdata[`DCE_B_CMPOFF];
            end
            if (hit(paddr, `DCE_OFF_STAT)) begin
                clr = clr | pwdata[NCMP-1:0];
            end
            if (hit(paddr, `DCE_OFF_MASK)) begin
                next_int_mask = pwdata[NCMP-1:0];
            end
        end
        // Total power-down beats a write in the same cycle; the enables
        // stay cleared after exit until software sets them again
        if (tpd) begin
            for (int i = 0; i < NCMP; i++) begin
                next_cfg[i].en = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg      <= '0;
            int_mask <= '0;
            cmp_off  <= `DCE_RST_CMPOFF;
        end else begin
            cfg      <= next_cfg;
            int_mask <= next_int_mask;
            cmp_off  <= next_cmp_off;
        end
    end

    // Read data, captured in the setup phase and held through access
    // Sampling at setup keeps prdata steady in the access cycle; an event
    // that lands in the access cycle shows on the next read
    always_comb begin
        next_prdata = prdata;
        if (setup) begin
            next_prdata = `DCE_RST_WORD;
            for (int i = 0; i < NCMP; i++) begin
                if (hit(paddr, cfg_addr(i))) begin
                    next_prdata[`DCE_B_EN]      = cfg[i].en;
                    next_prdata[`DCE_B_POSB]    = cfg[i].pos_b;
                    next_prdata[`DCE_B_NEGREF]  = cfg[i].neg_ref;
                    next_prdata[`DCE_B_PINEN]   = cfg[i].pin_en;
                    next_prdata[`DCE_B_INTEN]   = int_mask[i];
                    next_prdata[`DCE_B_RESULT]  = result[i];
                    next_prdata[`DCE_B_FLAG]    = flag[i];
                    next_prdata[`DCE_B_SETTLED] = settled[i];
                end
            end
            if (hit(paddr, `DCE_OFF_PWR)) begin
                next_prdata[`DCE_B_MODE_HI:`DCE_B_MODE_LO] = pwr_mode;
                next_prdata[`DCE_B_CMPOFF] = cmp_off;
            end
            if (hit(paddr, `DCE_OFF_STAT)) begin
                next_prdata[NCMP-1:0] = flag;
            end
            if (hit(paddr, `DCE_OFF_MASK)) begin
                next_prdata[NCMP-1:0] = int_mask;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata <= `DCE_RST_WORD;
        end else begin
            prdata <= next_prdata;
        end
    end

    // Comparator channels and their front-end control
    // The front end drops out with the off bit or total power-down
    for (genvar g = 0; g < NCMP; g++) begin : g_cmp
        assign en_eff[g] = cfg[g].en & ~cmp_off & ~tpd;
        assign fe_ctl[g] = '{en: en_eff[g], pos_b: cfg[g].pos_b,
                             neg_ref: cfg[g].neg_ref};
        dce_cmp_chan #(
            .SETTLE (SETTLE)
        ) u_chan (
            .clk     (clk),
            .rst_b   (rst_b),
            .en      (en_eff[g]),
            .raw_gt  (raw_gt[g]),
            .clr     (clr[g]),
            .result  (result[g]),
            .flag    (flag[g]),
            .change  (change[g]),
            .settled (settled[g])
        );
    end

    // Pin routing, shared interrupt and wake request
    // A routed pin is driven both ways from a flop on clk, so it follows the
    // result one clock later and changes only while clk runs
    always_comb begin
        for (int i = 0; i < NCMP; i++) begin
            next_pin[i]  = result[i] & cfg[i].pin_en;
            next_oe_b[i] = ~cfg[i].pin_en;
        end
        next_irq  = (|(flag & int_mask)) & ~tpd;
        next_wake = next_irq & asleep;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cmp_pin_out  <= '0;
            cmp_pin_oe_b <= '1;
            irq          <= 1'b0;
            wake         <= 1'b0;
        end else begin
            cmp_pin_out  <= next_pin;
            cmp_pin_oe_b <= next_oe_b;
            irq          <= next_irq;
            wake         <= next_wake;
        end
    end

    // All checks run on clk and rest while reset is held, so the forced
    // reset values never count as changes
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_irq_source: assert property (
        (|(flag & int_mask)) && !tpd |=> irq)
        else $error("Enabled change flag raised no interrupt");
    a_irq_masked: assert property (
        !(|(flag & int_mask)) |=> !irq)
        else $error("Interrupt without an enabled flag");
    a_wake_sleep: assert property (
        (|(flag & int_mask)) && asleep |=> wake && irq)
        else $error("Sleeping core not woken by comparator");
    a_tpd_off: assert property (
        tpd |=> (&result) && !irq && !wake)
        else $error("Total power-down left a comparator on");
    a_pwr_off: assert property (
        cmp_off |-> en_eff == '0 ##1 (&result))
        else $error("Power control bit did not stop comparators");
    a_pin_route: assert property (
        cfg[0].pin_en |=> cmp_pin_out[0] == $past(result[0]) && !cmp_pin_oe_b[0])
        else $error("Result not routed to its pin");
    a_read_flag: assert property (
        setup && hit(paddr, `DCE_OFF_STAT) |=> prdata[NCMP-1:0] == $past(flag))
        else $error("Status read does not show change flags");

    // Wake gating, power control register and interrupt mask register
    a_wake_awake: assert property (
        !asleep |=> !wake)
        else $error("Wake request outside idle or power-down");
    a_pwr_write: assert property (
        wr && hit(paddr, `DCE_OFF_PWR) |=> cmp_off == $past(pwdata[`DCE_B_CMPOFF]))
        else $error("Power control write did not reach the off bit");
    a_pwr_read: assert property (
        setup && hit(paddr, `DCE_OFF_PWR) |=> prdata[`DCE_B_CMPOFF] == $past(cmp_off))
        else $error("Power control read does not show the off bit");
    a_mask_write: assert property (
        wr && hit(paddr, `DCE_OFF_MASK) |=> int_mask == $past(pwdata[NCMP-1:0]))
        else $error("Mask write did not reach the interrupt enables");

    // Per-channel register view, flag clears, power-down and pin routing;
    // a change in the clearing cycle is left out because the set wins then
    for (genvar g = 0; g < NCMP; g++) begin : g_chk
        a_cfg_view: assert property (
            setup && hit(paddr, cfg_addr(g))
            |=> prdata[`DCE_B_RESULT] == $past(result[g])
                && prdata[`DCE_B_FLAG] == $past(flag[g]))
            else $error("Configuration read does not show result and flag");
        a_cfg_write: assert property (
            wr && hit(paddr, cfg_addr(g))
            |=> cfg[g].pos_b == $past(pwdata[`DCE_B_POSB])
                && cfg[g].neg_ref == $past(pwdata[`DCE_B_NEGREF]))
            else $error("Input selection write did not land");
        a_stat_clear: assert property (
            wr && hit(paddr, `DCE_OFF_STAT) && pwdata[g] && !change[g] |=> !flag[g])
            else $error("Status write of one did not clear the flag");
        a_cfg_clear: assert property (
            wr && hit(paddr, cfg_addr(g)) && !pwdata[`DCE_B_FLAG] && !change[g]
            |=> !flag[g])
            else $error("Configuration write of zero did not clear the flag");
        a_set_wins: assert property (change[g] |=> flag[g])
            else $error("Change did not set the flag");
        a_tpd_clear_en: assert property (tpd |=> !cfg[g].en)
            else $error("Total power-down left an enable set");
        a_pin_off: assert property (
            !cfg[g].pin_en |=> !cmp_pin_out[g] && cmp_pin_oe_b[g])
            else $error("Pin driven while routing is off");
    end

    c_flag_set:  cover property (change[0] ##1 flag[0]);
    c_irq_both:  cover property (flag[0] && flag[1] && irq);
    c_wake:      cover property (asleep ##1 wake);
    c_tpd_entry: cover property (!tpd ##1 tpd);
    c_pwr_off:   cover property ($rose(cmp_off));
endmodule

/* verification/dce_fe_model.sv */
/*
 * Behavioural analog front end: two voltage comparators with selectable inputs.
 * Assumes pin voltages in millivolts from the bench and fe_ctl from dce_top.
 */
`timescale 1ns/10ps
module dce_fe_model #(
    parameter int          NCMP    = 2,
    parameter logic [11:0] VREF_MV = 12'h4ce
) (
    input  wire logic                        clk,
    input  dce_pkg::dce_fe_t [NCMP-1:0]      fe_ctl,
    input  wire logic [NCMP-1:0][2:0][11:0]  pin_mv,
    output logic      [NCMP-1:0]             raw_gt
);
    logic        churn = 1'b0;
    logic [11:0] pos;
    logic [11:0] neg;

    // A powered-down comparator gives no stable answer
    always @(posedge clk) begin
        churn <= ~churn;
    end

    // Input selection and compare
    always_comb begin
        for (int i = 0; i < NCMP; i++) begin
            pos = fe_ctl[i].pos_b ? pin_mv[i][1] : pin_mv[i][0];
            neg = fe_ctl[i].neg_ref ? VREF_MV : pin_mv[i][2];
            raw_gt[i] = fe_ctl[i].en ? (pos > neg) : churn;
        end
    end
endmodule

/* verification/dce_top_tb.sv */
/*
 * Self-checking bench of dce_top: APB master, random and corner cases.
 * Assumes dce_fe_model as the analog front end and a 10 MHz clock.
 */
`timescale 1ns/10ps
`include "dce_consts.svh"
module dce_top_tb;
    localparam int NCMP   = 2;
    localparam int SETTLE = 4;
    logic                        clk      = 1'b0;
    logic                        rst_b    = 1'b0;
    logic                        psel     = 1'b0;
    logic                        penable  = 1'b0;
    logic                        pwrite   = 1'b0;
    logic [7:0]                  paddr    = 8'h00;
    logic [31:0]                 pwdata   = 32'h0;
    logic [31:0]                 prdata;
    logic                        pready;
    logic                        pslverr;
    dce_pkg::dce_mode_t          pwr_mode = dce_pkg::MODE_RUN;
    logic [NCMP-1:0]             raw_gt;
    dce_pkg::dce_fe_t [NCMP-1:0] fe_ctl;
    logic [NCMP-1:0]             cmp_pin_out;
    logic [NCMP-1:0]             cmp_pin_oe_b;
    logic                        irq;
    logic                        wake;
    logic [NCMP-1:0][2:0][11:0]  pin_mv   = '0;
    int                          miscompares = 0;
    int                          compares    = 0;

    always #50 clk = ~clk;

    dce_top #(.NCMP(NCMP), .SETTLE(SETTLE)) i_dce_top (
        .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pwr_mode(pwr_mode), .raw_gt(raw_gt), .fe_ctl(fe_ctl),
        .cmp_pin_out(cmp_pin_out), .cmp_pin_oe_b(cmp_pin_oe_b), .irq(irq), .wake(wake));

    dce_fe_model #(.NCMP(NCMP)) i_dce_fe_model (
        .clk(clk), .fe_ctl(fe_ctl), .pin_mv(pin_mv), .raw_gt(raw_gt));

    // Verdict and end of run
    task automatic wrap_up;
        if (miscompares == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Comparisons
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask

    // One APB transfer, bounded wait on pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic err);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            miscompares++;
            wrap_up();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk_word(r, exp);
        chk_bit(e, 1'b0);
    endtask

    // Expected values
    function automatic logic [7:0] cfg_addr(input int i);
        return `DCE_OFF_CFG0 + 8'(i) * `DCE_CFG_STEP;
    endfunction

    function automatic logic [31:0] cfg_exp(input logic [4:0] c, input logic res,
                                            input logic flg, input logic set);
        return {24'h0, set, flg, res, c};
    endfunction

    function automatic logic exp_gt(input int i, input logic pb, input logic nr);
        logic [11:0] p;
        logic [11:0] n;
        p = pb ? pin_mv[i][1] : pin_mv[i][0];
        n = nr ? 12'h4ce : pin_mv[i][2];
        return p > n;
    endfunction

    // Main sequence
    initial begin
        logic [31:0] r;
        logic        e;
        logic [4:0]  c;
        logic        x;
        int          i;
        void'($urandom(32'h2ac09e44));
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        // Reset state and unmapped access
        for (i = 0; i < NCMP; i++) rd_chk(cfg_addr(i), cfg_exp(5'h0, 1'b1, 1'b0, 1'b0));
        rd_chk(`DCE_OFF_STAT, 32'h0);
        apb(1'b0, 8'h14, 32'h0, r, e);
        chk_bit(e, 1'b1);
        chk_bit(pready, 1'b1);
        chk_word({30'h0, cmp_pin_oe_b}, 32'h3);
        // Every input selection on both comparators, random voltages
        for (int k = 0; k < 8; k++) begin
            i = k % 2;
            c = {1'b0, 1'($urandom), k[2], k[1], 1'b1};
            for (int j = 0; j < 3; j++) pin_mv[i][j] <= 12'($urandom_range(3300));
            wr(cfg_addr(i), {27'h0, c});
            repeat (SETTLE + 6) @(posedge clk);
            wr(cfg_addr(i), {27'h0, c});
            x = exp_gt(i, k[1], k[2]);
            rd_chk(cfg_addr(i), cfg_exp(c, x, 1'b0, 1'b1));
            chk_bit(cmp_pin_out[i], c[3] & x);
            chk_bit(cmp_pin_oe_b[i], ~c[3]);
            chk_word({29'h0, fe_ctl[i]}, {29'h0, 1'b1, k[1], k[2]});
            wr(cfg_addr(i), 32'h0);
            rd_chk(cfg_addr(i), cfg_exp(5'h0, 1'b1, ~x, 1'b0));
            wr(cfg_addr(i), 32'h0);
        end
        // Flag, mask, shared interrupt, wake, power modes
        for (i = 0; i < NCMP; i++) begin
            pin_mv[i] <= {12'h3e8, 12'h000, 12'h7d0};
            wr(cfg_addr(i), 32'h1);
            repeat (SETTLE + 6) @(posedge clk);
            wr(cfg_addr(i), 32'h1);
            pin_mv[i][0] <= 12'h1f4;
            repeat (6) @(posedge clk);
            chk_bit(irq, 1'b0);
            rd_chk(`DCE_OFF_STAT, 32'h1 << i);
            rd_chk(cfg_addr(i), cfg_exp(5'h1, 1'b0, 1'b1, 1'b1));
            wr(`DCE_OFF_MASK, 32'h1 << i);
            repeat (2) @(posedge clk);
            chk_bit(irq, 1'b1);
            chk_bit(wake, 1'b0);
            pwr_mode <= dce_pkg::MODE_IDLE;
            repeat (2) @(posedge clk);
            chk_bit(wake, 1'b1);
            pwr_mode <= dce_pkg::MODE_PD;
            repeat (2) @(posedge clk);
            chk_bit(wake, 1'b1);
            pwr_mode <= dce_pkg::MODE_RUN;
            rd_chk(`DCE_OFF_STAT, 32'h1 << i);
            wr(`DCE_OFF_STAT, 32'h1 << i);
            repeat (2) @(posedge clk);
            chk_bit(irq, 1'b0);
            pin_mv[i][0] <= 12'h7d0;
            repeat (6) @(posedge clk);
            chk_bit(irq, 1'b1);
            wr(`DCE_OFF_STAT, 32'h3);
            pwr_mode <= dce_pkg::MODE_TPD;
            repeat (6) @(posedge clk);
            chk_bit(fe_ctl[i].en, 1'b0);
            chk_bit(irq | wake, 1'b0);
            pwr_mode <= dce_pkg::MODE_RUN;
            rd_chk(cfg_addr(i), cfg_exp(5'h10, 1'b1, 1'b0, 1'b0));
            wr(`DCE_OFF_MASK, 32'h0);
            wr(`DCE_OFF_STAT, 32'h3);
        end
        // Shared power-off bit
        wr(cfg_addr(0), 32'h1);
        wr(cfg_addr(1), 32'h1);
        wr(`DCE_OFF_PWR, 32'h20);
        repeat (4) @(posedge clk);
        chk_word({30'h0, fe_ctl[1].en, fe_ctl[0].en}, 32'h0);
        rd_chk(`DCE_OFF_PWR, 32'h20);
        wr(`DCE_OFF_PWR, 32'h0);
        repeat (4) @(posedge clk);
        chk_word({30'h0, fe_ctl[1].en, fe_ctl[0].en}, 32'h3);
        // Mid-run reset clears a change flag that is set
        pin_mv[0][0] <= 12'h1f4;
        repeat (6) @(posedge clk);
        rd_chk(cfg_addr(0), cfg_exp(5'h1, 1'b0, 1'b1, 1'b1));
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rd_chk(`DCE_OFF_STAT, 32'h0);
        rd_chk(cfg_addr(0), cfg_exp(5'h0, 1'b1, 1'b0, 1'b0));
        chk_bit(irq, 1'b0);
        wrap_up();
    end
endmodule
